// ===== mwp_pkg.sv
package mwp_pkg;
  // -------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int CELL_NS = 155;
  localparam int CELL_MAX_NS = 310;
  localparam int CLK_TO_DATA_PS = 232500;
  localparam int ON_TIME_NS = 30;
  localparam int FAR_SHIFT_NS = 12;
  localparam int NEAR_SHIFT_NS = 7;
  localparam int TICK_NS = 20;
  localparam int PULSE_NS = 35;
  localparam int ON_TIME_CYC = (ON_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int FAR_CYC = (FAR_SHIFT_NS + CLK_NS - 1) / CLK_NS;
  localparam int NEAR_CYC = (NEAR_SHIFT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] TICK_CYC = 4'((TICK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  // Extra cycle covers the enable window before its trailing edge
  localparam logic [4:0] DLY_BASE = 5'(ON_TIME_CYC + 1);
  // -------------------------------------------------------------
  // Reset values and pipeline fill
  // -------------------------------------------------------------
  localparam logic [3:0] WIN_RST = 4'h0;
  localparam logic [2:0] PRIME_CELLS = 3'h4;
  // -------------------------------------------------------------
  // Precompensation positions
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    SH_EARLY_FAR = 3'b000,
    SH_EARLY_NEAR = 3'b001,
    SH_NOMINAL = 3'b010,
    SH_LATE_NEAR = 3'b011,
    SH_LATE_FAR = 3'b100
  } mwp_shift_t;

  function automatic logic [4:0] mwp_delay(input mwp_shift_t s);
    unique case (s)
      SH_EARLY_FAR: mwp_delay = DLY_BASE - 5'(FAR_CYC);
      SH_EARLY_NEAR: mwp_delay = DLY_BASE - 5'(NEAR_CYC);
      SH_NOMINAL: mwp_delay = DLY_BASE;
      SH_LATE_NEAR: mwp_delay = DLY_BASE + 5'(NEAR_CYC);
      SH_LATE_FAR: mwp_delay = DLY_BASE + 5'(FAR_CYC);
      default: mwp_delay = DLY_BASE;
    endcase
  endfunction
endpackage

// ===== mwp_write_precomp.sv
`timescale 1ns/1ps
module mwp_write_precomp (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic double_rate_write_timing,
  input wire logic double_rate_write_timing_inv,
  input wire logic write_data,
  input wire logic write_strobe,
  input wire logic write_gate_n,
  input wire logic mark_gap_inhibit_n,
  output logic encoded_write_pulses_n,
  output logic half_cell_tick_n,
  output logic bit_cell_tick,
  output logic clock_data_enable_n,
  output logic timing_pair_fault
);
  import mwp_pkg::*;

  // -------------------------------------------------------------
  // Link domain: reset and input resampling
  // -------------------------------------------------------------
  logic wrst_m_r;
  logic wrst_r;
  logic stb_m_r;
  logic stb_s_r;
  logic stb_d_r;
  logic dat_m_r;
  logic dat_s_r;
  logic cap_r;

  // Gate high or system reset holds the link side cleared
  always_ff @(posedge double_rate_write_timing) begin
    wrst_m_r <= rst | write_gate_n;
    wrst_r <= wrst_m_r;
  end

  always_ff @(posedge double_rate_write_timing) begin
    stb_m_r <= write_strobe;
    stb_s_r <= stb_m_r;
    stb_d_r <= stb_s_r;
    dat_m_r <= write_data;
    dat_s_r <= dat_m_r;
  end

  // Data moves only at strobe fall, so the strobe rise is mid-bit
  always_ff @(posedge double_rate_write_timing) begin
    if (wrst_r) begin
      cap_r <= 1'b0;
    end else if (stb_s_r && !stb_d_r) begin
      cap_r <= dat_s_r;
    end
  end

  // -------------------------------------------------------------
  // Link domain: MFM encoder and precomp selector
  // -------------------------------------------------------------
  // win_r[0] next, [1] current, [2] previous, [3] one before that
  logic phase_r;
  logic [3:0] win_r;
  logic [2:0] prime_r;
  logic ev_tog_r;
  mwp_shift_t ev_shift_r;
  logic primed;

  assign primed = (prime_r == PRIME_CELLS);

  function automatic mwp_shift_t clk_shift(input logic [3:0] w);
    if (w[3] && !w[0]) begin
      clk_shift = SH_LATE_NEAR;
    end else if (!w[3] && w[0]) begin
      clk_shift = SH_EARLY_NEAR;
    end else begin
      clk_shift = SH_NOMINAL;
    end
  endfunction

  function automatic mwp_shift_t data_shift(input logic [3:0] w);
    if (!w[2] && w[0]) begin
      data_shift = w[3] ? SH_EARLY_NEAR : SH_EARLY_FAR;
    end else if (w[2] && !w[0]) begin
      data_shift = w[3] ? SH_LATE_FAR : SH_LATE_NEAR;
    end else begin
      data_shift = SH_NOMINAL;
    end
  endfunction

  // Each timing cycle is one half cell: boundary slot, then mid slot
  always_ff @(posedge double_rate_write_timing) begin
    if (wrst_r) begin
      phase_r <= 1'b0;
      win_r <= WIN_RST;
      prime_r <= 3'h0;
      ev_tog_r <= 1'b0;
      ev_shift_r <= SH_NOMINAL;
    end else begin
      phase_r <= ~phase_r;
      if (!phase_r) begin
        if (primed && !win_r[2] && !win_r[1]) begin
          ev_tog_r <= ~ev_tog_r;
          ev_shift_r <= clk_shift(win_r);
        end
      end else begin
        if (primed && win_r[1]) begin
          ev_tog_r <= ~ev_tog_r;
          ev_shift_r <= data_shift(win_r);
        end
        win_r <= {win_r[2:0], cap_r};
        if (!primed) begin
          prime_r <= prime_r + 3'h1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // System domain: crossings
  // -------------------------------------------------------------
  logic gate_m_r;
  logic gate_off_r;
  logic inh_m_r;
  logic inh_r;
  logic tog_m_r;
  logic tog_s_r;
  logic tog_d_r;
  logic ph_m_r;
  logic ph_s_r;
  logic wtp_m_r;
  logic wtp_s_r;
  logic wtp_d_r;
  logic wtn_m_r;
  logic wtn_s_r;
  logic wtn_d_r;
  logic ev;
  logic wt_fall;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gate_m_r <= 1'b1;
      gate_off_r <= 1'b1;
      inh_m_r <= 1'b0;
      inh_r <= 1'b0;
    end else begin
      gate_m_r <= write_gate_n;
      gate_off_r <= gate_m_r;
      inh_m_r <= ~mark_gap_inhibit_n;
      inh_r <= inh_m_r;
    end
  end

  // Shift code is stable a half cell, far longer than the toggle path
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tog_m_r <= 1'b0;
      tog_s_r <= 1'b0;
      tog_d_r <= 1'b0;
      ph_m_r <= 1'b0;
      ph_s_r <= 1'b0;
    end else begin
      tog_m_r <= ev_tog_r;
      tog_s_r <= tog_m_r;
      tog_d_r <= tog_s_r;
      ph_m_r <= phase_r;
      ph_s_r <= ph_m_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wtp_m_r <= 1'b0;
      wtp_s_r <= 1'b0;
      wtp_d_r <= 1'b0;
      wtn_m_r <= 1'b1;
      wtn_s_r <= 1'b1;
      wtn_d_r <= 1'b1;
    end else begin
      wtp_m_r <= double_rate_write_timing;
      wtp_s_r <= wtp_m_r;
      wtp_d_r <= wtp_s_r;
      wtn_m_r <= double_rate_write_timing_inv;
      wtn_s_r <= wtn_m_r;
      wtn_d_r <= wtn_s_r;
    end
  end

  assign ev = (tog_s_r ^ tog_d_r) && !gate_off_r;
  assign wt_fall = wtp_d_r && !wtp_s_r && !gate_off_r;

  // -------------------------------------------------------------
  // System domain: observation outputs
  // -------------------------------------------------------------
  logic [3:0] tick_cnt_r;

  always_ff @(posedge clk_sys) begin
    if (rst || gate_off_r) begin
      tick_cnt_r <= 4'h0;
      half_cell_tick_n <= 1'b1;
    end else begin
      if (wt_fall) begin
        tick_cnt_r <= TICK_CYC;
      end else if (tick_cnt_r != 4'h0) begin
        tick_cnt_r <= tick_cnt_r - 4'h1;
      end
      half_cell_tick_n <= !(wt_fall || tick_cnt_r > 4'h1);
    end
  end

  // Shifts happen on the half cell after capture, well clear of data edges
  always_ff @(posedge clk_sys) begin
    if (rst || gate_off_r) begin
      bit_cell_tick <= 1'b0;
    end else begin
      bit_cell_tick <= ph_s_r;
    end
  end

  // Both halves equal for two samples means the pair is broken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timing_pair_fault <= 1'b0;
    end else begin
      timing_pair_fault <= (wtp_s_r == wtn_s_r) && (wtp_d_r == wtn_d_r);
    end
  end

  // -------------------------------------------------------------
  // System domain: delay chain and write pulse
  // -------------------------------------------------------------
  logic [4:0] dly_r;
  logic [3:0] pw_r;
  logic pulse_act_r;

  always_ff @(posedge clk_sys) begin
    if (rst || gate_off_r) begin
      clock_data_enable_n <= 1'b1;
    end else begin
      clock_data_enable_n <= !ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || gate_off_r) begin
      dly_r <= 5'h00;
    end else if (ev) begin
      dly_r <= mwp_delay(ev_shift_r);
    end else if (dly_r != 5'h00) begin
      dly_r <= dly_r - 5'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || gate_off_r) begin
      pulse_act_r <= 1'b0;
      pw_r <= 4'h0;
    end else if (dly_r == 5'h01) begin
      pulse_act_r <= 1'b1;
      pw_r <= PULSE_CYC - 4'h1;
    end else if (pw_r != 4'h0) begin
      pw_r <= pw_r - 4'h1;
    end else begin
      pulse_act_r <= 1'b0;
    end
  end

  // Inhibit gates the pin, so a pulse cut by a mark edge is shortened
  always_ff @(posedge clk_sys) begin
    if (rst || gate_off_r) begin
      encoded_write_pulses_n <= 1'b1;
    end else begin
      encoded_write_pulses_n <= !(pulse_act_r && !inh_r);
    end
  end

  // -------------------------------------------------------------
  // Assertions: link domain
  // -------------------------------------------------------------
  AST_RESAMPLE: assert property (
    @(posedge double_rate_write_timing) disable iff (wrst_r)
    (stb_s_r && !stb_d_r) |=> (cap_r == $past(dat_s_r)))
    else $error("captured bit differs from sampled data");

  AST_MFM_CLOCK: assert property (
    @(posedge double_rate_write_timing) disable iff (wrst_r)
    (!phase_r && primed && !win_r[2] && !win_r[1])
    |=> (ev_tog_r != $past(ev_tog_r)))
    else $error("missing clock pulse between zeros");

  AST_MFM_QUIET: assert property (
    @(posedge double_rate_write_timing) disable iff (wrst_r)
    (!phase_r && (win_r[2] || win_r[1])) |=> $stable(ev_tog_r))
    else $error("clock pulse next to a one");

  AST_MFM_DATA: assert property (
    @(posedge double_rate_write_timing) disable iff (wrst_r)
    (phase_r && primed) |=> ((ev_tog_r != $past(ev_tog_r)) == $past(win_r[1])))
    else $error("data pulse does not match bit");

  // -------------------------------------------------------------
  // Assertions: system domain
  // -------------------------------------------------------------
  sequence s_window;
    !clock_data_enable_n ##1 clock_data_enable_n;
  endsequence

  sequence s_pulse;
    pulse_act_r [*5] ##1 pulse_act_r [*4] ##1 !pulse_act_r;
  endsequence

  AST_ON_TIME: assert property (
    @(posedge clk_sys) disable iff (rst || gate_off_r)
    (ev && ev_shift_r == SH_NOMINAL) |=> s_window ##8 $rose(pulse_act_r))
    else $error("on-time pulse not 30 ns after window");

  AST_EARLY_FAR: assert property (
    @(posedge clk_sys) disable iff (rst || gate_off_r)
    (ev && ev_shift_r == SH_EARLY_FAR) |-> ##7 $rose(pulse_act_r))
    else $error("early far pulse misplaced");

  AST_LATE_FAR: assert property (
    @(posedge clk_sys) disable iff (rst || gate_off_r)
    (ev && ev_shift_r == SH_LATE_FAR) |-> ##13 $rose(pulse_act_r))
    else $error("late far pulse misplaced");

  AST_WIDTH: assert property (
    @(posedge clk_sys) disable iff (rst || gate_off_r)
    $rose(pulse_act_r) |-> s_pulse)
    else $error("write pulse width not nine cycles");

  AST_OUT_FOLLOWS: assert property (
    @(posedge clk_sys) disable iff (rst || gate_off_r)
    (!inh_r && !$past(gate_off_r)) |=> (encoded_write_pulses_n == !$past(pulse_act_r)))
    else $error("write output does not follow pulse");

  AST_INHIBIT: assert property (
    @(posedge clk_sys) disable iff (rst)
    inh_r |=> encoded_write_pulses_n)
    else $error("write pulse during mark gap");

  AST_GATE_HALT: assert property (
    @(posedge clk_sys) disable iff (rst)
    gate_off_r |=> (!pulse_act_r && dly_r == 5'h00 && encoded_write_pulses_n
                    && half_cell_tick_n && clock_data_enable_n))
    else $error("activity while write gate is off");

  AST_TICK: assert property (
    @(posedge clk_sys) disable iff (rst || gate_off_r)
    wt_fall |=> (!half_cell_tick_n) [*5] ##1 half_cell_tick_n)
    else $error("half-cell tick not five cycles low");

endmodule // mwp_write_precomp

// ===== mwp_host_model.sv
`timescale 1ns/1ps
module mwp_host_model (
  input wire logic clk_link,
  input wire logic en,
  input wire logic [7:0] pat,
  input wire logic [2:0] len,
  output logic strobe,
  output logic data
);
  logic [2:0] idx = 3'h0;
  logic primed = 1'b0;
  initial strobe = 1'b0;
  initial data = 1'b0;
  function automatic logic [2:0] nx(input logic [2:0] i);
    nx = (i == len - 3'h1) ? 3'h0 : i + 3'h1;
  endfunction
  // -----------------------------------------------------------
  // Strobe at half the timing rate, phase fixed by that clock
  // -----------------------------------------------------------
  always @(posedge clk_link) begin
    if (!en) begin
      strobe <= 1'b0;
      data <= ~data; // Idle line keeps moving, never a stale bit
      idx <= 3'h0;
      primed <= 1'b0;
    end else if (!primed) begin
      data <= pat[0];
      idx <= nx(3'h0);
      primed <= 1'b1;
    end else if (!strobe) begin
      strobe <= 1'b1;
    end else begin
      strobe <= 1'b0;
      data <= pat[idx];
      idx <= nx(idx);
    end
  end
endmodule // mwp_host_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import mwp_pkg::*;
  localparam int CELL = 80;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic tmg = 1'b0;
  logic tmg_inv;
  logic pair_bad = 1'b0;
  logic gate_n = 1'b1;
  logic mark_n = 1'b1;
  logic host_en = 1'b0;
  logic [7:0] pat = 8'hFF;
  logic [2:0] len = 3'h1;
  logic strobe, wdata, enc_n, tick_n, cell_tick, cde_n, fault;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int cde_at = 0;
  int fall_at = 0;
  int tick_at = 0;
  int last_fall, npulse, ntick, ncell, imin, imax, wmin, wmax, tmin, tmax;
  logic [31:0] mask;
  logic mon = 1'b0;
  logic enc_q = 1'b1;
  logic tick_q = 1'b1;
  logic cell_q = 1'b0;
  always #2 clk_sys = ~clk_sys;
  // Timing clock free running, phase unrelated to clk_sys
  initial begin
    #37.3;
    forever #80 tmg = ~tmg;
  end
  assign tmg_inv = pair_bad ? tmg : ~tmg;
  mwp_write_precomp DUT (.clk_sys(clk_sys), .rst(rst), .double_rate_write_timing(tmg),
    .double_rate_write_timing_inv(tmg_inv), .write_data(wdata), .write_strobe(strobe),
    .write_gate_n(gate_n), .mark_gap_inhibit_n(mark_n), .encoded_write_pulses_n(enc_n),
    .half_cell_tick_n(tick_n), .bit_cell_tick(cell_tick), .clock_data_enable_n(cde_n),
    .timing_pair_fault(fault));
  mwp_host_model host (.clk_link(tmg), .en(host_en), .pat(pat), .len(len),
    .strobe(strobe), .data(wdata));
  // -----------------------------------------------------------
  // Pulse monitor
  // -----------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cde_n === 1'b0) cde_at = cyc;
    if (enc_q === 1'b1 && enc_n === 1'b0) begin
      fall_at = cyc;
      if (mon) begin
        npulse++;
        if (cyc - cde_at < 32) mask = mask | (32'h1 << (cyc - cde_at));
        if (last_fall >= 0 && cyc - last_fall < imin) imin = cyc - last_fall;
        if (last_fall >= 0 && cyc - last_fall > imax) imax = cyc - last_fall;
        last_fall = cyc;
      end
    end
    if (mon && enc_q === 1'b0 && enc_n === 1'b1) begin
      if (cyc - fall_at < wmin) wmin = cyc - fall_at;
      if (cyc - fall_at > wmax) wmax = cyc - fall_at;
    end
    if (tick_q === 1'b1 && tick_n === 1'b0) begin
      tick_at = cyc;
      if (mon) ntick++;
    end
    if (mon && tick_q === 1'b0 && tick_n === 1'b1) begin
      if (cyc - tick_at < tmin) tmin = cyc - tick_at;
      if (cyc - tick_at > tmax) tmax = cyc - tick_at;
    end
    if (mon && cell_q === 1'b0 && cell_tick === 1'b1) ncell++;
    enc_q = enc_n;
    tick_q = tick_n;
    cell_q = cell_tick;
  end
  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic measure(input int n);
    #1;
    last_fall = -1;
    npulse = 0;
    ntick = 0;
    ncell = 0;
    mask = 32'h0;
    imin = 99999;
    imax = 0;
    wmin = 99999;
    wmax = 0;
    tmin = 99999;
    tmax = 0;
    mon = 1'b1;
    wait_cyc(n);
    #1;
    mon = 1'b0;
  endtask
  // Skips the window fill and pipeline, then measures whole cells
  task automatic run(input logic [7:0] p, input logic [2:0] l, input int cells);
    @(posedge clk_sys);
    pat <= p;
    len <= l;
    gate_n <= 1'b0;
    host_en <= 1'b1;
    wait_cyc(10 * CELL);
    measure(cells * CELL);
  endtask
  task automatic stop;
    @(posedge clk_sys);
    gate_n <= 1'b1;
    host_en <= 1'b0;
    // Gate stays high over several link edges so the link side really resets
    wait_cyc(2 * CELL);
  endtask
  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  task automatic t_reset;
    check(enc_n, 1'b1);
    check(tick_n, 1'b1);
    check(cell_tick, 1'b0);
    check(cde_n, 1'b1);
    check(fault, 1'b0);
  endtask
  task automatic t_ones_then_gate_off;
    run(8'hFF, 3'h1, 20);
    check(npulse, 20);
    check(imin, CELL);
    check(imax, CELL);
    check(mask, 32'h400);
    check(wmin, 9);
    check(wmax, 9);
    check(tmin, 5);
    check(tmax, 5);
    check(ncell, 20);
    @(posedge clk_sys);
    gate_n <= 1'b1;
    wait_cyc(8);
    measure(400);
    check(npulse, 0);
    check(ntick, 0);
    check(enc_n, 1'b1);
    stop();
  endtask
  task automatic t_zeros;
    run(8'h00, 3'h1, 20);
    check(npulse, 20);
    check(imin, CELL);
    check(imax, CELL);
    stop();
  endtask
  task automatic t_sparse;
    run(8'h01, 3'h2, 20);
    check(npulse, 10);
    check(imin, 2 * CELL);
    check(imax, 2 * CELL);
    stop();
    run(8'h01, 3'h3, 21);
    check(npulse, 14);
    check(imin, 3 * CELL / 2);
    check(imax, 3 * CELL / 2);
    stop();
  endtask
  // Mask bit n marks a pulse n cycles after its window: 7/8 early, 10 on time, 12/13 late
  task automatic t_precomp;
    run(8'h0D, 3'h4, 24);
    check(mask, 32'h2500);
    stop();
    run(8'h16, 3'h5, 25);
    check(npulse, 15);
    check(mask, 32'h1500);
    stop();
    run(8'h0C, 3'h4, 24);
    check(npulse, 18);
    check(mask, 32'h1480);
    stop();
    run(8'h01, 3'h4, 24);
    check(npulse, 18);
    check(mask, 32'h1500);
    stop();
  endtask
  task automatic t_inhibit;
    @(posedge clk_sys);
    mark_n <= 1'b0;
    run(8'hFF, 3'h1, 10);
    check(npulse, 0);
    stop();
    mark_n <= 1'b1;
  endtask
  task automatic t_pair;
    @(posedge clk_sys);
    pair_bad <= 1'b1;
    wait_cyc(20);
    check(fault, 1'b1);
    pair_bad <= 1'b0;
    wait_cyc(20);
    check(fault, 1'b0);
  endtask
  task automatic results;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    wait_cyc(4);
    t_reset();
    t_ones_then_gate_off();
    t_zeros();
    t_sparse();
    t_precomp();
    t_inhibit();
    t_pair();
    results();
  end
endmodule // tb
